/* atf_task_file.v */
// upper task file register bank: cylinder high, drive/head, status, control
`timescale 1ns/1ps
`default_nettype none
module atf_task_file (
   input  wire       clock,
   input  wire       reset,
   input  wire [3:0] reg_addr,
   input  wire [7:0] write_data,
   input  wire       write_strobe,
   input  wire       read_strobe,
   input  wire       cmd_strobe,
   input  wire       ctrl_strobe,
   input  wire [5:0] config_index,
   input  wire       level_irq_mode,
   input  wire       drive_id,
   input  wire       drive_active,
   input  wire       busy_done,
   input  wire       ready_in,
   input  wire       write_fault_in,
   input  wire       seek_done_in,
   input  wire       data_req_set,
   input  wire       corrected_in,
   input  wire       error_set,
   input  wire       irq_event,
   output reg  [7:0] read_data,
   output reg        read_data_oe,
   output reg        read_bit7_oe,
   output reg  [7:0] command_code,
   output reg        command_valid,
   output wire       request_ok,
   output wire       lba_mode,
   output wire [3:0] head_lba_high,
   output wire [7:0] lba_mid_high,
   output wire       slave_selected,
   output wire       task_file_reset,
   output wire       interrupt_request_n
);
`include "atf_map.vh"
   reg  [7:0] cylinder_high_address;
   reg  [7:0] drive_head_select;
   reg  [7:0] device_control;
   reg        irq_pending;
   wire [7:0] primary_status;
   wire       soft_reset_bit;
   wire       interrupt_disable_bit;
   wire       io_mode;
   wire       status_read;
   wire       cmd_write;
   wire [7:0] drive_address_readback;
   wire       write_gate_n;
   wire       head_select3_n;
   wire       head_select0_n;
   wire [3:0] head_select_n;
   wire       drive1_selected_n;
   wire       drive0_selected_n;
   wire       drive_select_bit;
   ////////////////////////////////////////////////////////////////////////
   // device control; only bits 2 and 1 are acted on
   always @(posedge clock) begin
      if (reset)
         device_control <= `ATF_DEV_CTRL_RST;
      else if (ctrl_strobe)
         device_control <= {4'h0, 1'b1, write_data[2:1], 1'b0};
   end
   assign soft_reset_bit        = device_control[`ATF_DC_SOFT_RESET_BIT];
   assign interrupt_disable_bit = device_control[`ATF_DC_INTERRUPT_DISABLE_BIT];
   assign task_file_reset = soft_reset_bit;
   ////////////////////////////////////////////////////////////////////////
   // addressing registers; soft reset restores their reset values (00, A0) but not config state
   always @(posedge clock) begin
      if (reset || task_file_reset) begin
         cylinder_high_address <= `ATF_CYL_HIGH_RST;
         drive_head_select     <= `ATF_DRIVE_HEAD_RST;
      end else if (write_strobe) begin
         if (reg_addr == `ATF_SEL_CYL_HIGH)
            cylinder_high_address <= write_data;
         if (reg_addr == `ATF_SEL_DRIVE_HEAD)
            drive_head_select <= write_data;
      end
   end
   assign lba_mid_high     = cylinder_high_address;
   assign lba_mode         = drive_head_select[`ATF_DH_LBA];
   assign drive_select_bit = drive_head_select[`ATF_DH_DRV];
   assign slave_selected   = drive_select_bit;
   assign head_lba_high    = drive_head_select[3:0];
   ////////////////////////////////////////////////////////////////////////
   // command register; writes while busy are dropped
   assign cmd_write = cmd_strobe & ~primary_status[`ATF_ST_BSY] & ~task_file_reset;
   always @(posedge clock) begin
      if (reset || task_file_reset) begin
         command_code  <= 8'h00;
         command_valid <= 1'b0;
      end else begin
         command_valid <= cmd_write;
         if (cmd_write)
            command_code <= write_data;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   atf_status_reg u_status (
      .clock          (clock),
      .reset          (reset),
      .clear          (task_file_reset),
      .cmd_write      (cmd_write),
      .busy_done      (busy_done),
      .ready_in       (ready_in),
      .write_fault_in (write_fault_in),
      .seek_done_in   (seek_done_in),
      .data_req_set   (data_req_set),
      .corrected_in   (corrected_in),
      .error_set      (error_set),
      .status         (primary_status)
   );
   // requests allowed when not busy, ready and seeked
   assign request_ok = ~primary_status[`ATF_ST_BSY] & primary_status[`ATF_ST_DRIVE_READY_FLAG]
                       & primary_status[`ATF_ST_DSC];
   ////////////////////////////////////////////////////////////////////////
   // drive address readback
   assign write_gate_n      = 1'b0;
   // inverted head bits, one per bit
   genvar hs;
   generate
      for (hs = 0; hs < 4; hs = hs + 1) begin : g_head_sel
         assign head_select_n[hs] = ~drive_head_select[hs];
      end
   endgenerate
   assign head_select3_n    = head_select_n[3];
   assign head_select0_n    = head_select_n[0];
   assign drive1_selected_n = ~(drive_active & drive_select_bit);
   assign drive0_selected_n = ~(drive_active & ~drive_select_bit);
   // write gate zero, bit 7 floats
   assign drive_address_readback = {1'b0, write_gate_n, head_select3_n,
                                    head_select_n[2:1], head_select0_n,
                                    drive1_selected_n, drive0_selected_n};
   ////////////////////////////////////////////////////////////////////////
   // read mux, registered; bit 7 drive dropped for the drive address
   always @(posedge clock) begin
      if (reset) begin
         read_data    <= 8'h00;
         read_data_oe <= 1'b0;
         read_bit7_oe <= 1'b0;
      end else begin
         read_data_oe <= read_strobe;
         read_bit7_oe <= read_strobe & (reg_addr != `ATF_SEL_DRIVE_ADDR);
         case (reg_addr)
            `ATF_SEL_CYL_HIGH:   read_data <= cylinder_high_address;
            `ATF_SEL_DRIVE_HEAD: read_data <= drive_head_select;
            `ATF_SEL_STATUS:     read_data <= primary_status;
            `ATF_SEL_ALT_STATUS: read_data <= primary_status;
            `ATF_SEL_DRIVE_ADDR: read_data <= drive_address_readback;
            default:             read_data <= 8'h00;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // interrupt: pending until a primary status read in level io mode
   assign io_mode     = (config_index >= `ATF_IDX_IO_LO) && (config_index <= `ATF_IDX_IO_HI);
   assign status_read = read_strobe & (reg_addr == `ATF_SEL_STATUS);
   always @(posedge clock) begin
      if (reset || task_file_reset)
         irq_pending <= 1'b0;
      else if (irq_event)
         irq_pending <= 1'b1;  // set wins over the read clear
      else if (status_read && io_mode && level_irq_mode)
         irq_pending <= 1'b0;
   end
   assign interrupt_request_n = ~(irq_pending & ~interrupt_disable_bit);
endmodule
`default_nettype wire

/* atf_map.vh */
// register selects, bit positions and reset values of the upper task file bank
`ifndef ATF_MAP_VH
`define ATF_MAP_VH
// register selects on reg_addr: {alt_block, a2, a1, a0}
`define ATF_SEL_CYL_HIGH    4'h5
`define ATF_SEL_DRIVE_HEAD  4'h6
`define ATF_SEL_STATUS      4'h7
`define ATF_SEL_ALT_STATUS  4'hE
`define ATF_SEL_DRIVE_ADDR  4'hF
// drive/head fields
`define ATF_DH_LBA          6
`define ATF_DH_DRV          4
// status bits
`define ATF_ST_BSY          7
`define ATF_ST_DRIVE_READY_FLAG         6
`define ATF_ST_DWF          5
`define ATF_ST_DSC          4
`define ATF_ST_DRQ          3
`define ATF_ST_CORRECTED_DATA_FLAG         2
`define ATF_ST_IDX          1
`define ATF_ST_ERR          0
// device control bits
`define ATF_DC_SOFT_RESET_BIT         2
`define ATF_DC_INTERRUPT_DISABLE_BIT         1
// drive address bits
`define ATF_DA_FLOAT        7
`define ATF_DA_WTG          6
// reset values
`define ATF_CYL_HIGH_RST    8'h00
`define ATF_DRIVE_HEAD_RST  8'hA0
`define ATF_DEV_CTRL_RST    8'h08
// config index values that run in i/o card mode
`define ATF_IDX_IO_LO       6'h01
`define ATF_IDX_IO_HI       6'h03
`endif

/* atf_status_reg.v */
// status flag holder fed by the command engine
`timescale 1ns/1ps
`default_nettype none
module atf_status_reg (
   input  wire       clock,
   input  wire       reset,
   input  wire       clear,
   input  wire       cmd_write,
   input  wire       busy_done,
   input  wire       ready_in,
   input  wire       write_fault_in,
   input  wire       seek_done_in,
   input  wire       data_req_set,
   input  wire       corrected_in,
   input  wire       error_set,
   output reg  [7:0] status
);
`include "atf_map.vh"
   reg busy_flag;
   reg drive_ready_flag;
   reg write_fault_flag;
   reg seek_complete_flag;
   reg data_request_flag;
   reg corrected_data_flag;
   reg error_flag;
   ////////////////////////////////////////////////////////////////////////
   // flags; busy, data request and error: set wins over its own clear, but reset or clear drops every flag
   always @(posedge clock) begin
      if (reset || clear) begin
         busy_flag           <= 1'b0;
         drive_ready_flag    <= 1'b0;
         write_fault_flag    <= 1'b0;
         seek_complete_flag  <= 1'b0;
         data_request_flag   <= 1'b0;
         corrected_data_flag <= 1'b0;
         error_flag          <= 1'b0;
      end else begin
         if (cmd_write)
            busy_flag <= 1'b1;
         else if (busy_done)
            busy_flag <= 1'b0;
         drive_ready_flag    <= ready_in;
         write_fault_flag    <= write_fault_in;
         seek_complete_flag  <= seek_done_in;
         corrected_data_flag <= corrected_in;
         if (data_req_set)
            data_request_flag <= 1'b1;
         else if (cmd_write)
            data_request_flag <= 1'b0;
         if (error_set)
            error_flag <= 1'b1;
         else if (cmd_write)
            error_flag <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // status byte assembly, registered
   always @(posedge clock) begin
      if (reset || clear) begin
         status <= 8'h00;
      end else begin
         status[`ATF_ST_BSY]  <= busy_flag | cmd_write;
         status[`ATF_ST_DRIVE_READY_FLAG] <= drive_ready_flag;
         status[`ATF_ST_DWF]  <= write_fault_flag;
         status[`ATF_ST_DSC]  <= seek_complete_flag;
         status[`ATF_ST_DRQ]  <= data_request_flag;
         status[`ATF_ST_CORRECTED_DATA_FLAG] <= corrected_data_flag;
         status[`ATF_ST_IDX]  <= 1'b0;
         status[`ATF_ST_ERR]  <= error_flag;
      end
   end
endmodule
`default_nettype wire

/* atf_task_file_monitor.sv */
// concurrent checks on the ports of the upper task file bank
`timescale 1ns/1ps
`default_nettype none
module atf_task_file_monitor (
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       write_strobe,
   input wire logic       read_strobe,
   input wire logic       cmd_strobe,
   input wire logic       ctrl_strobe,
   input wire logic       level_irq_mode,
   input wire logic       irq_event,
   input wire logic       read_data_oe,
   input wire logic       read_bit7_oe,
   input wire logic       command_valid,
   input wire logic       request_ok,
   input wire logic       lba_mode,
   input wire logic       slave_selected,
   input wire logic       task_file_reset,
   input wire logic       interrupt_request_n,
   input wire logic [3:0] reg_addr,
   input wire logic [3:0] head_lba_high,
   input wire logic [5:0] config_index,
   input wire logic [7:0] write_data,
   input wire logic [7:0] read_data,
   input wire logic [7:0] command_code,
   input wire logic [7:0] lba_mid_high
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_cyl_capture:
   assert property (write_strobe && reg_addr == 4'h5 && !task_file_reset
      |=> lba_mid_high == $past(write_data)) else $error("cylinder high not captured");
   a_head_fields:
   assert property (write_strobe && reg_addr == 4'h6 && !task_file_reset
      |=> {lba_mode, slave_selected, head_lba_high} == {$past(write_data[6]),
      $past(write_data[4]), $past(write_data[3:0])}) else $error("drive/head fields wrong");
   a_drive_addr:
   assert property (read_strobe && reg_addr == 4'hF && !write_strobe
      |=> read_data_oe && !read_bit7_oe && read_data[6:2] == {1'b0, ~$past(head_lba_high)})
      else $error("drive address readback wrong");
   a_cmd_accept:
   assert property (cmd_strobe && request_ok && !task_file_reset
      |=> command_valid && command_code == $past(write_data)) else $error("command lost");
   a_busy_refuses:
   assert property (command_valid |-> !request_ok ##1 !command_valid)
      else $error("command taken while busy");
   a_index_zero:
   assert property (read_strobe && (reg_addr == 4'h7 || reg_addr == 4'hE)
      |=> read_data[1] == 1'b0) else $error("index bit set");
   a_alt_keeps_irq:
   assert property (read_strobe && reg_addr == 4'hE && !interrupt_request_n && !ctrl_strobe
      |=> !interrupt_request_n) else $error("alternate read dropped interrupt");
   a_status_drops_irq:
   assert property (read_strobe && reg_addr == 4'h7 && level_irq_mode && !irq_event
      && config_index >= 6'h01 && config_index <= 6'h03 |=> interrupt_request_n)
      else $error("status read kept interrupt");
endmodule
bind atf_task_file atf_task_file_monitor atf_task_file_monitor_inst (.clock, .reset,
   .write_strobe, .read_strobe, .cmd_strobe, .ctrl_strobe, .level_irq_mode, .irq_event,
   .read_data_oe, .read_bit7_oe, .command_valid, .request_ok, .lba_mode, .slave_selected,
   .task_file_reset, .interrupt_request_n, .reg_addr, .head_lba_high, .config_index,
   .write_data, .read_data, .command_code, .lba_mid_high);
`default_nettype wire

/* atf_host_model.sv */
// host side model driving the i/o strobes of the task file bank
`timescale 1ns/1ps
`default_nettype none
module atf_host_model (
   input  wire logic       clock,
   input  wire logic       request_ok,
   input  wire logic [7:0] read_data,
   output var  logic [3:0] reg_addr,
   output var  logic [7:0] write_data,
   output var  logic       write_strobe,
   output var  logic       read_strobe,
   output var  logic       cmd_strobe,
   output var  logic       ctrl_strobe
);
   initial begin
      reg_addr = 4'h0;
      write_data = 8'h00;
      {write_strobe, read_strobe, cmd_strobe, ctrl_strobe} = 4'h0;
   end
   // kind: 0 reg write, 1 command, 2 control, 3 read, 4 command without ready wait
   task automatic access(input int kind, input logic [3:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      // commands wait for ready, kind 4 skips this on purpose
      if (kind == 1)
         repeat (20) if (request_ok !== 1'b1) @(posedge clock);
      @(posedge clock);
      #1;
      reg_addr = addr;
      // obsolete ones and fixed control bits
      write_data = (kind == 0 && addr == 4'h6) ? (wdata | 8'hA0) :
                   (kind == 2) ? ((wdata | 8'h08) & 8'hFE) : wdata;
      write_strobe = (kind == 0);
      cmd_strobe = (kind == 1 || kind == 4);
      ctrl_strobe = (kind == 2);
      read_strobe = (kind == 3);
      @(posedge clock);
      #1;
      {write_strobe, read_strobe, cmd_strobe, ctrl_strobe} = 4'h0;
      rdata = read_data;
      // released bus shows a changed pattern, never the stale byte
      write_data = ~write_data;
   endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the upper task file bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clock, reset, write_strobe, read_strobe, cmd_strobe, ctrl_strobe;
   logic       level_irq_mode, drive_active, read_data_oe, read_bit7_oe, command_valid;
   logic       request_ok, lba_mode, slave_selected, task_file_reset, interrupt_request_n;
   logic [3:0] reg_addr, head_lba_high, lv, ev;
   logic [5:0] config_index;
   logic [7:0] write_data, read_data, command_code, lba_mid_high, d;
   int         fails = 0, n_tests = 0;
   atf_task_file atf_task_file_inst (.clock, .reset, .reg_addr, .write_data, .write_strobe,
      .read_strobe, .cmd_strobe, .ctrl_strobe, .config_index, .level_irq_mode,
      .drive_id(1'b0), .drive_active, .busy_done(ev[3]), .data_req_set(ev[2]),
      .error_set(ev[1]), .irq_event(ev[0]), .ready_in(lv[3]), .write_fault_in(lv[2]),
      .seek_done_in(lv[1]), .corrected_in(lv[0]), .read_data, .read_data_oe,
      .read_bit7_oe, .command_code, .command_valid, .request_ok, .lba_mode, .head_lba_high,
      .lba_mid_high, .slave_selected, .task_file_reset, .interrupt_request_n);
   atf_host_model atf_host_model_inst (.clock, .request_ok, .read_data, .reg_addr,
      .write_data, .write_strobe, .read_strobe, .cmd_strobe, .ctrl_strobe);
   initial begin
      clock = 0;
      forever #2 clock = ~clock;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input int kind, input logic [3:0] a, input logic [7:0] v);
      logic [7:0] dummy;
      atf_host_model_inst.access(kind, a, v, dummy);
   endtask
   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] got;
      atf_host_model_inst.access(3, a, 8'h00, got);
      check(got, exp);
   endtask
   // engine events {busy_done, data_req_set, error_set, irq_event}, one cycle
   task automatic ev_pulse(input logic [3:0] v);
      @(posedge clock);
      #1 ev = v;
      @(posedge clock);
      #1 ev = 4'h0;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // whole sequence needs well under a thousand cycles
   initial begin
      #40000;
      fails++;
      $display("[FAIL] %0t timeout", $time);
      end_sim;
   end
   initial begin
      {reset, lv, ev, config_index, level_irq_mode, drive_active} = {1'b1, 15'h0000, 1'b1};
      repeat (12) @(posedge clock);
      #1 reset = 0;
      rchk(4'h5, 8'h00);
      rchk(4'h6, 8'hA0);
      atf_host_model_inst.access(3, 4'hF, 8'h00, d);
      check(d & 8'h7F, 8'h3E);
      rchk(4'h0, 8'h00);
      check({7'h00, request_ok}, 8'h00);
      $display("done: reset values");
      wr(0, 4'h5, 8'h5A);
      rchk(4'h5, 8'h5A);
      wr(0, 4'h6, 8'h59);
      check({2'b00, lba_mode, slave_selected, head_lba_high}, 8'h39);
      rchk(4'h6, 8'hF9);
      atf_host_model_inst.access(3, 4'hF, 8'h00, d);
      check(d & 8'h7F, 8'h19);
      drive_active = 0;
      atf_host_model_inst.access(3, 4'hF, 8'h00, d);
      check(d & 8'h7F, 8'h1B);
      drive_active = 1;
      $display("done: addressing");
      lv = 4'hF;
      repeat (3) @(posedge clock);
      rchk(4'h7, 8'h74);
      rchk(4'hE, 8'h74);
      check({7'h00, request_ok}, 8'h01);
      ev_pulse(4'h6);
      repeat (2) @(posedge clock);
      rchk(4'h7, 8'h7D);
      wr(1, 4'h7, 8'hEC);
      check({7'h00, command_valid}, 8'h01);
      check(command_code, 8'hEC);
      check({7'h00, request_ok}, 8'h00);
      rchk(4'h7, 8'hF4);
      wr(4, 4'h7, 8'h20);
      check({7'h00, command_valid}, 8'h00);
      check(command_code, 8'hEC);
      ev_pulse(4'h8);
      repeat (2) @(posedge clock);
      rchk(4'h7, 8'h74);
      $display("done: status and command");
      level_irq_mode = 1;
      ev_pulse(4'h1);
      check({7'h00, interrupt_request_n}, 8'h00);
      rchk(4'hE, 8'h74);
      check({7'h00, interrupt_request_n}, 8'h00);
      for (int i = 1; i <= 3; i++) begin
         config_index = i[5:0];
         ev_pulse(4'h1);
         rchk(4'h7, 8'h74);
         check({7'h00, interrupt_request_n}, 8'h01);
      end
      wr(2, 4'hE, 8'h02);
      ev_pulse(4'h1);
      check({7'h00, interrupt_request_n}, 8'h01);
      $display("done: interrupt");
      wr(2, 4'hE, 8'h04);
      check({7'h00, task_file_reset}, 8'h01);
      wr(0, 4'h5, 8'h33);
      wr(2, 4'hE, 8'h00);
      check({7'h00, task_file_reset}, 8'h00);
      rchk(4'h5, 8'h00);
      $display("done: soft reset");
      end_sim;
   end
endmodule
`default_nettype wire
